/* strobe_port_pkg.sv */
// Shared constants for the strobe/acknowledge host register port
package strobe_port_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int REG_COUNT = 128;
   // Clock period and settling time before acknowledge
   localparam int CLK_PERIOD_NS = 100;
   localparam int ACK_SETTLE_NS = 200;
   // Least time rounds up, at least one cycle
   localparam int ACK_SETTLE_RAW = (ACK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_SETTLE_CYC = (ACK_SETTLE_RAW < 1) ? 1 : ACK_SETTLE_RAW;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] ACK_SETTLE_CNT = CNT_W'(ACK_SETTLE_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   // Reset values and the undriven data bus level
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
   // Read/write level sampled at the data strobe's falling edge
   localparam logic RW_READ = 1'b1;
   localparam logic RW_WRITE = 1'b0;
   // Level of the bus style strap that selects this bus style
   localparam logic STYLE_STROBE_ACK = 1'b1;
endpackage

/* strobe_port_if.sv */
// Pin bundle between host and device ends of the strobe register port
`timescale 1ns/10ps
`default_nettype none
interface strobe_port_if;
   import strobe_port_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic cs_n;
   logic addr_latch_strobe_n;
   logic data_strobe_n;
   logic rw;
   logic [DATA_W-1:0] host_data_out;
   logic host_data_oe;
   logic [DATA_W-1:0] dev_data_out;
   logic dev_data_oe;
   logic transfer_ack_n;
   logic [DATA_W-1:0] data_bus;
   // Resolved shared data bus; undriven bus reads as pulled up
   assign data_bus = host_data_oe ? host_data_out : (dev_data_oe ? dev_data_out : BUS_IDLE);
   modport dev (
      input addr, cs_n, addr_latch_strobe_n, data_strobe_n, rw, data_bus,
      output dev_data_out, dev_data_oe, transfer_ack_n
   );
   modport host (
      input transfer_ack_n, data_bus,
      output addr, cs_n, addr_latch_strobe_n, data_strobe_n, rw, host_data_out, host_data_oe
   );
endinterface
`default_nettype wire

/* strobe_port_host.sv */
// Host end: runs strobe/acknowledge read and write cycles on request
`timescale 1ns/10ps
`default_nettype none
module strobe_port_host #(
   parameter int ADDR_BITS = 7,
   parameter int DATA_BITS = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   strobe_port_if.host bus,
   input wire logic req,
   input wire logic req_write,
   input wire logic [strobe_port_pkg::ADDR_W-1:0] req_addr,
   input wire logic [strobe_port_pkg::DATA_W-1:0] req_wdata,
   output logic busy,
   output logic done,
   output logic [strobe_port_pkg::DATA_W-1:0] rdata
);
   import strobe_port_pkg::*;

   if (ADDR_BITS != ADDR_W || DATA_BITS != DATA_W) begin : g_bad_width
      $error("strobe_port_host: widths must match the pin bundle");
   end

   typedef enum logic [3:0] {
      H_IDLE = 4'h1,
      H_ADDR = 4'h2,
      H_WAIT = 4'h4,
      H_END = 4'h8
   } host_state_t;

   host_state_t state_reg, state_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
   logic sel_n_reg, sel_n_next, ds_n_reg, ds_n_next, rw_reg, rw_next;
   logic doe_reg, doe_next, busy_reg, busy_next, done_reg, done_next;

   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      sel_n_next = sel_n_reg;
      ds_n_next = ds_n_reg;
      rw_next = rw_reg;
      doe_next = doe_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      case (state_reg)
         H_IDLE: begin
            if (req) begin
               // Chip select and address strobe fall together, as when tied
               addr_next = req_addr;
               wdata_next = req_wdata;
               rw_next = req_write ? RW_WRITE : RW_READ;
               doe_next = req_write;
               sel_n_next = 1'b0;
               busy_next = 1'b1;
               state_next = H_ADDR;
            end
         end
         H_ADDR: begin
            ds_n_next = 1'b0;
            state_next = H_WAIT;
         end
         H_WAIT: begin
            // Strobes stay asserted until acknowledge is seen low
            if (!bus.transfer_ack_n) begin
               if (rw_reg == RW_READ) begin
                  rdata_next = bus.data_bus;
               end
               ds_n_next = 1'b1;
               state_next = H_END;
            end
         end
         H_END: begin
            // Address strobe held low until the cycle is over
            sel_n_next = 1'b1;
            doe_next = 1'b0;
            busy_next = 1'b0;
            done_next = 1'b1;
            state_next = H_IDLE;
         end
         default: begin
            state_next = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_reg <= H_IDLE;
         addr_reg <= ADDR_RESET;
         wdata_reg <= REG_RESET;
         rdata_reg <= REG_RESET;
         sel_n_reg <= 1'b1;
         ds_n_reg <= 1'b1;
         rw_reg <= RW_READ;
         doe_reg <= 1'b0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
         sel_n_reg <= sel_n_next;
         ds_n_reg <= ds_n_next;
         rw_reg <= rw_next;
         doe_reg <= doe_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end

   assign bus.addr = addr_reg;
   assign bus.cs_n = sel_n_reg;
   assign bus.addr_latch_strobe_n = sel_n_reg;
   assign bus.data_strobe_n = ds_n_reg;
   assign bus.rw = rw_reg;
   assign bus.host_data_out = wdata_reg;
   assign bus.host_data_oe = doe_reg;
   assign busy = busy_reg;
   assign done = done_reg;
   assign rdata = rdata_reg;
endmodule
`default_nettype wire

/* strobe_port_dev.sv */
// Device end: register file behind the strobe/acknowledge host port
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Address strobe low lets address in
// - Host drops address strobe, holds to end
// - Strobe and chip select may fall together
// - Shared read pin acts as data strobe
// - Acknowledge low only when cycle can finish
// - Host waits for acknowledge before next cycle
// - Host stretches cycle while acknowledge high
// - Read/write high at strobe fall reads
// - Read/write low at strobe fall writes
// - Style strap high selects this bus style
// - Read drives addressed register onto data bus
// - Write captured when data strobe rises
module strobe_port_dev #(
   parameter int ADDR_BITS = 7,
   parameter int DATA_BITS = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic host_bus_style_sel,
   strobe_port_if.dev bus,
   input wire logic [strobe_port_pkg::ADDR_W-1:0] user_addr,
   output logic [strobe_port_pkg::DATA_W-1:0] user_rdata,
   output logic wr_pulse,
   output logic [strobe_port_pkg::ADDR_W-1:0] wr_addr,
   output logic [strobe_port_pkg::DATA_W-1:0] wr_data,
   output logic style_active
);
   import strobe_port_pkg::*;

   if (ADDR_BITS != ADDR_W || DATA_BITS != DATA_W) begin : g_bad_width
      $error("strobe_port_dev: widths must match the pin bundle");
   end
   if (ACK_SETTLE_CYC >= (1 << CNT_W)) begin : g_bad_count
      $error("strobe_port_dev: settle count does not fit its counter");
   end

   // Read and write paths share one settle counter
   function automatic logic settle_over(input logic [CNT_W-1:0] cnt);
      return cnt <= 4'h1;
   endfunction

   function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] cnt);
      return cnt - 4'h1;
   endfunction

   typedef enum logic [5:0] {
      D_IDLE = 6'h01,
      D_RD_SETTLE = 6'h02,
      D_RD_ACK = 6'h04,
      D_WR_SETTLE = 6'h08,
      D_WR_ACK = 6'h10,
      D_RELEASE = 6'h20
   } dev_state_t;

   logic [DATA_W-1:0] regs [0:REG_COUNT-1];

   dev_state_t state_reg, state_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic ds_prev_reg, ds_prev_next;
   logic ack_n_reg, ack_n_next;
   logic doe_reg, doe_next;
   logic [DATA_W-1:0] dout_reg, dout_next;
   logic [DATA_W-1:0] wdata_hold_reg, wdata_hold_next;
   logic wr_pulse_reg, wr_pulse_next;
   logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
   logic [DATA_W-1:0] wr_data_reg, wr_data_next;
   logic [DATA_W-1:0] user_rdata_reg;
   logic style_reg;
   logic in_reset_reg;

   logic selected;
   logic ds_fall;
   logic ds_rise;
   logic abort;

   // Bus style strap is caught while reset is held, and once more at the
   // first edge after release, so a strap settling late is still seen.
   always_ff @(posedge ref_clk) begin
      in_reset_reg <= reset;
      if (reset || in_reset_reg) begin
         style_reg <= (host_bus_style_sel == STYLE_STROBE_ACK);
      end
   end

   // Register file write and user-side read
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regs[i] <= REG_RESET;
         end
         user_rdata_reg <= REG_RESET;
      end else begin
         if (wr_pulse_next) begin
            regs[wr_addr_next] <= wr_data_next;
         end
         user_rdata_reg <= regs[user_addr];
      end
   end

   // Tied strobe and chip select need both low at once, with the style strap latched high
   assign selected = !bus.cs_n && !bus.addr_latch_strobe_n && style_reg;
   // Shared read pin is the data strobe in this style
   assign ds_fall = ds_prev_reg && !bus.data_strobe_n;
   assign ds_rise = !ds_prev_reg && bus.data_strobe_n;
   // Losing chip select or strobe mid-cycle ends it without a write
   assign abort = bus.cs_n || bus.data_strobe_n;

   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      cnt_next = cnt_reg;
      ds_prev_next = bus.data_strobe_n;
      ack_n_next = ack_n_reg;
      doe_next = doe_reg;
      dout_next = dout_reg;
      wdata_hold_next = wdata_hold_reg;
      wr_pulse_next = 1'b0;
      wr_addr_next = wr_addr_reg;
      wr_data_next = wr_data_reg;
      case (state_reg)
         D_IDLE: begin
            ack_n_next = 1'b1;
            doe_next = 1'b0;
            // Address follows the pins while selected and the data strobe is high
            if (selected && bus.data_strobe_n) begin
               addr_next = bus.addr;
            end
            if (selected && ds_fall) begin
               if (bus.rw == RW_READ) begin
                  // Read chosen by the level at the strobe's fall
                  doe_next = 1'b1;
                  dout_next = regs[addr_reg];
                  state_next = D_RD_SETTLE;
               end else begin
                  state_next = D_WR_SETTLE;
               end
               cnt_next = ACK_SETTLE_CNT;
            end
         end
         D_RD_SETTLE: begin
            // Acknowledge held high while read data settles
            dout_next = regs[addr_reg];
            if (abort) begin
               state_next = D_RELEASE;
            end else if (settle_over(cnt_reg)) begin
               ack_n_next = 1'b0;
               state_next = D_RD_ACK;
            end else begin
               cnt_next = count_down(cnt_reg);
            end
         end
         D_RD_ACK: begin
            if (abort) begin
               ack_n_next = 1'b1;
               doe_next = 1'b0;
               state_next = D_IDLE;
            end
         end
         D_WR_SETTLE: begin
            wdata_hold_next = bus.data_bus;
            if (abort) begin
               state_next = D_RELEASE;
            end else if (settle_over(cnt_reg)) begin
               ack_n_next = 1'b0;
               state_next = D_WR_ACK;
            end else begin
               cnt_next = count_down(cnt_reg);
            end
         end
         D_WR_ACK: begin
            // Data is taken from the last cycle with the strobe low, since
            // the host may drop its drivers as soon as the strobe rises.
            if (!abort) begin
               wdata_hold_next = bus.data_bus;
            end else begin
               if (ds_rise && !bus.cs_n) begin
                  wr_pulse_next = 1'b1;
                  wr_addr_next = addr_reg;
                  wr_data_next = wdata_hold_reg;
               end
               ack_n_next = 1'b1;
               state_next = D_IDLE;
            end
         end
         D_RELEASE: begin
            ack_n_next = 1'b1;
            doe_next = 1'b0;
            state_next = D_IDLE;
         end
         default: begin
            state_next = D_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_reg <= D_IDLE;
         addr_reg <= ADDR_RESET;
         cnt_reg <= CNT_ZERO;
         ds_prev_reg <= 1'b1;
         ack_n_reg <= 1'b1;
         doe_reg <= 1'b0;
         dout_reg <= REG_RESET;
         wdata_hold_reg <= REG_RESET;
         wr_pulse_reg <= 1'b0;
         wr_addr_reg <= ADDR_RESET;
         wr_data_reg <= REG_RESET;
      end else begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         cnt_reg <= cnt_next;
         ds_prev_reg <= ds_prev_next;
         ack_n_reg <= ack_n_next;
         doe_reg <= doe_next;
         dout_reg <= dout_next;
         wdata_hold_reg <= wdata_hold_next;
         wr_pulse_reg <= wr_pulse_next;
         wr_addr_reg <= wr_addr_next;
         wr_data_reg <= wr_data_next;
      end
   end

   assign bus.transfer_ack_n = ack_n_reg;
   assign bus.dev_data_oe = doe_reg;
   assign bus.dev_data_out = dout_reg;
   assign user_rdata = user_rdata_reg;
   assign wr_pulse = wr_pulse_reg;
   assign wr_addr = wr_addr_reg;
   assign wr_data = wr_data_reg;
   assign style_active = style_reg;
endmodule
`default_nettype wire

/* strobe_port_assertions.sv */
// Pin-level checks on the strobe port between host and device ends
`timescale 1ns/10ps
`default_nettype none
module strobe_port_assertions (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [strobe_port_pkg::ADDR_W-1:0] addr,
   input wire logic cs_n,
   input wire logic addr_latch_strobe_n,
   input wire logic data_strobe_n,
   input wire logic rw,
   input wire logic host_data_oe,
   input wire logic dev_data_oe,
   input wire logic transfer_ack_n
);
   import strobe_port_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_ack_after_settle: assert property (
      $fell(data_strobe_n) && !cs_n |-> transfer_ack_n [*3] ##1 !transfer_ack_n)
      else $error("acknowledge not low three edges after data strobe fall");
   a_ack_needs_strobe: assert property (
      $fell(transfer_ack_n) |-> !data_strobe_n && !cs_n)
      else $error("acknowledge fell outside a strobed cycle");
   a_ack_release_bus: assert property (
      !transfer_ack_n && data_strobe_n |=> transfer_ack_n && !dev_data_oe)
      else $error("acknowledge or data drive kept after strobe release");
   a_read_drives_bus: assert property (
      $fell(data_strobe_n) && !cs_n && rw |=> dev_data_oe)
      else $error("device not driving data bus on read");
   a_write_no_drive: assert property (
      !data_strobe_n && !rw |-> !dev_data_oe)
      else $error("device drives data bus during write");
   a_no_bus_fight: assert property (
      !(host_data_oe && dev_data_oe))
      else $error("host and device drive data bus together");
   a_strobe_tied_cs: assert property (
      addr_latch_strobe_n == cs_n)
      else $error("address strobe differs from chip select");
   a_addr_held: assert property (
      !data_strobe_n && !$fell(data_strobe_n) |-> $stable(addr) && $stable(rw))
      else $error("address or direction moved during data strobe");
   a_cycle_stretched: assert property (
      !data_strobe_n && transfer_ack_n |=> !data_strobe_n)
      else $error("data strobe released before acknowledge");
   a_next_after_ack: assert property (
      $rose(data_strobe_n) |-> $past(transfer_ack_n) == 1'b0)
      else $error("cycle ended without acknowledge");
   a_strobe_in_select: assert property (
      !data_strobe_n |-> !cs_n && !addr_latch_strobe_n)
      else $error("data strobe low without chip select");
endmodule
`default_nettype wire

/* async_strobe_host_port_tb_top.sv */
// Self-checking bench: host and device ends joined back to back
`timescale 1ns/10ps
`default_nettype none
module async_strobe_host_port_tb_top;
   import strobe_port_pkg::*;
   logic ref_clk, reset, strap_b, req, req_write, busy, done, wr_pulse, style_active;
   logic wr_pulse_b, style_b;
   logic [ADDR_W-1:0] req_addr, user_addr, wr_addr, user_addr_b, last_wa;
   logic [DATA_W-1:0] req_wdata, rdata, user_rdata, wr_data, user_rdata_b, last_wd;
   logic [DATA_W-1:0] shadow [REG_COUNT];
   logic [31:0] rng;
   int failures, tests_run, wr_seen, exp_writes, acks_b, writes_b;
   strobe_port_if link();
   strobe_port_if bad_link();
   strobe_port_host i_strobe_port_host (.ref_clk(ref_clk), .reset(reset), .bus(link.host),
      .req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .busy(busy), .done(done), .rdata(rdata));
   strobe_port_dev i_strobe_port_dev (.ref_clk(ref_clk), .reset(reset),
      .host_bus_style_sel(1'b1), .bus(link.dev), .user_addr(user_addr),
      .user_rdata(user_rdata), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data),
      .style_active(style_active));
   // Second device faces a bench driver that breaks the host side on purpose
   strobe_port_dev i_strobe_port_dev_b (.ref_clk(ref_clk), .reset(reset),
      .host_bus_style_sel(strap_b), .bus(bad_link.dev), .user_addr(user_addr_b),
      .user_rdata(user_rdata_b), .wr_pulse(wr_pulse_b), .wr_addr(), .wr_data(),
      .style_active(style_b));
   strobe_port_assertions i_strobe_port_assertions (.ref_clk(ref_clk), .reset(reset),
      .addr(link.addr), .cs_n(link.cs_n), .addr_latch_strobe_n(link.addr_latch_strobe_n),
      .data_strobe_n(link.data_strobe_n), .rw(link.rw), .host_data_oe(link.host_data_oe),
      .dev_data_oe(link.dev_data_oe), .transfer_ack_n(link.transfer_ack_n));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [DATA_W-1:0] expected_read(input logic [ADDR_W-1:0] a);
      return shadow[a];
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Optional poke issues a second request while busy; it must be dropped
   task automatic host_op(input logic wr, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d, input logic poke);
      int n;
      n = 0;
      @(posedge ref_clk);
      req <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      last_wa = a;
      last_wd = d;
      @(posedge ref_clk);
      req <= 1'b0;
      #1;
      check("busy", busy, 1'b1);
      if (poke) begin
         @(posedge ref_clk);
         req <= 1'b1;
         req_write <= 1'b1;
         req_addr <= a ^ 7'h01;
         req_wdata <= ~d;
         @(posedge ref_clk);
         req <= 1'b0;
      end
      while (done !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check("done", done, 1'b1);
      if (wr) begin
         shadow[a] = d;
         exp_writes++;
         @(posedge ref_clk);
         user_addr <= a;
         repeat (2) @(posedge ref_clk);
         #1;
         check("user_rdata", user_rdata, d);
      end else begin
         check("rdata", rdata, expected_read(a));
      end
   endtask

   // Bench-driven cycle on the second link; ds held low for hold edges
   task automatic bad_cycle(input logic rd, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d, input int hold);
      @(posedge ref_clk);
      bad_link.cs_n <= 1'b0;
      bad_link.addr_latch_strobe_n <= 1'b0;
      bad_link.rw <= rd ? RW_READ : RW_WRITE;
      bad_link.addr <= a;
      bad_link.host_data_out <= d;
      bad_link.host_data_oe <= !rd;
      @(posedge ref_clk);
      bad_link.data_strobe_n <= 1'b0;
      repeat (hold) @(posedge ref_clk);
      bad_link.data_strobe_n <= 1'b1;
      @(posedge ref_clk);
      bad_link.cs_n <= 1'b1;
      bad_link.addr_latch_strobe_n <= 1'b1;
      bad_link.host_data_oe <= 1'b0;
      repeat (6) @(posedge ref_clk);
   endtask

   always @(posedge ref_clk) begin
      if (wr_pulse === 1'b1) begin
         wr_seen++;
         check("wr_addr", wr_addr, last_wa);
         check("wr_data", wr_data, last_wd);
      end
   end

   always @(negedge ref_clk) begin
      if (bad_link.transfer_ack_n === 1'b0) acks_b++;
      if (wr_pulse_b === 1'b1) writes_b++;
   end

   initial begin
      ref_clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
   end

   initial begin
      #(CLK_PERIOD_NS * 20000);
      failures++;
      tally_and_finish();
   end

   initial begin
      reset = 1'b1;
      strap_b = 1'b0;
      req = 1'b0;
      req_write = 1'b0;
      req_addr = 7'h00;
      req_wdata = 8'h00;
      user_addr = 7'h00;
      user_addr_b = 7'h05;
      bad_link.cs_n = 1'b1;
      bad_link.addr_latch_strobe_n = 1'b1;
      bad_link.data_strobe_n = 1'b1;
      bad_link.rw = RW_READ;
      bad_link.addr = 7'h00;
      bad_link.host_data_out = 8'h00;
      bad_link.host_data_oe = 1'b0;
      rng = 32'h65975076;
      foreach (shadow[i]) shadow[i] = 8'h00;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      bad_cycle(1'b0, 7'h05, 8'hA5, 8);
      check("style_b", style_b, 1'b0);
      reset <= 1'b1;
      strap_b <= 1'b1;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      bad_cycle(1'b0, 7'h05, 8'h5A, 1);
      // Read dropped before acknowledge must not be acknowledged either
      bad_cycle(1'b1, 7'h05, 8'h00, 1);
      check("ack_b", acks_b, 0);
      check("writes_b", writes_b, 0);
      check("user_rdata_b", user_rdata_b, 8'h00);
      // Strobe held well past acknowledge still commits once on release
      bad_cycle(1'b0, 7'h05, 8'h3C, 8);
      check("ack_b_seen", acks_b > 0, 1'b1);
      check("writes_b_one", writes_b, 1);
      check("user_rdata_b_wr", user_rdata_b, 8'h3C);
      check("style", style_active, 1'b1);
      host_op(1'b0, 7'h00, 8'h00, 1'b0);
      host_op(1'b1, 7'h00, 8'hFF, 1'b0);
      host_op(1'b1, 7'h7F, 8'h00, 1'b1);
      host_op(1'b1, 7'h7F, 8'hFF, 1'b0);
      host_op(1'b0, 7'h7F, 8'h00, 1'b0);
      for (int i = 0; i < 40; i++) begin
         rng = xorshift(rng);
         host_op(1'b1, rng[6:0], rng[15:8], rng[16]);
         if (rng[17]) host_op(1'b0, rng[6:0], 8'h00, rng[18]);
      end
      for (int a = 0; a < REG_COUNT; a++) host_op(1'b0, a[6:0], 8'h00, 1'b0);
      check("write_count", wr_seen, exp_writes);
      tally_and_finish();
   end
endmodule
`default_nettype wire
